// ---- rtl/ssr_pkg.sv ----
/*
 * constants for the safety status register bank: register selects, field positions,
 * reset values and watchdog counter figures.
 * assumes a single 40 MHz clock domain.
 */
`default_nettype none
package ssr_pkg;
	localparam logic [1:0] SEL_SUPPLY_A = 2'h0;
	localparam logic [1:0] SEL_RAIL_B = 2'h1;
	localparam logic [1:0] SEL_PROTECT = 2'h2;
	localparam logic [1:0] SEL_CRC_WD = 2'h3;
	localparam logic [7:0] RST_SUPPLY_A = 8'h00;
	localparam logic [7:0] RST_RAIL_B = 8'h00;
	localparam logic [7:0] RST_PROTECT = 8'h00;
	localparam logic [2:0] WD_CNT_DEFAULT = 3'h5;
	localparam logic [2:0] WD_CNT_MAX = 3'h7;
	localparam logic [2:0] WD_CNT_ENABLE_BELOW = 3'h5;
	localparam int BIT_CFG_CRC = 5;
	localparam int BIT_NVM_CRC = 4;
	localparam int BIT_PROT_RSV = 3;
	localparam logic [7:0] CRC8_POLY = 8'h07;
	localparam logic [7:0] CRC8_INIT = 8'hFF;
	typedef enum logic [2:0] {
		SSR_STANDBY,
		SSR_RESET,
		SSR_DIAG,
		SSR_ACTIVE,
		SSR_SAFE
	} ssr_state_t;
endpackage
`default_nettype wire

// ---- rtl/ssr_status_regs.sv ----
/*
 * read-only safety and supply-monitor status registers with crc checks and the
 * watchdog fail counter.
 * assumes monitor inputs are synchronous to clk_sys; the state machine that owns
 * the device state supplies diagState/stateEntry and consumes safeRequest.
 */
`default_nettype none
// Functional notes
// - battery overvoltage bit 7, undervoltage bit 6 of register a, live
// - high pump overvoltage bit 5, live
// - low pump overvoltage bit 4, undervoltage bit 3, live
// - monitor supply bad bit 2, live
// - reference below main band gap bit 1, above bit 0, live
// - register b holds live ov/uv pairs for four rails
// - transceiver undervoltage reported even when rail disabled
// - transceiver current limit bit 7, reads 1 while rail disabled
// - io rail current limit bit 6, live
// - sensor supply undervoltage bit 5, overvoltage bit 4, live
// - sensor overtemp bit 2 holds sensor regulator disabled
// - transceiver overtemp bit 1; when unmasked disables rail, clears enable
// - io overtemp bit 0 keeps io regulator disabled
// - crc8 over config registers, mismatch sets bit 5
// - clean nonvolatile crc check clears config crc error
// - crc8 over nonvolatile content, mismatch sets bit 4
// - nonvolatile crc error in diagnostic state requests safe state
// - 3-bit watchdog fail counter, default 5, reloaded on diag/active entry
// - counter increments on bad or timeout, decrements on good
// - enable drive held off until counter below 5
// - with reset enable, event after count 7 sets watchdog failure
// - crc and watchdog register reinitialised on power-on reset and self test
// - transceiver overtemp unmask defaults to 1
module ssr_status_regs
	import ssr_pkg::*;
#(
	parameter int CFG_BYTES = 4,
	parameter int NVM_BYTES = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic selfTestReinit,
	// monitor comparators
	input wire logic [7:0] supplyCond,
	input wire logic [7:0] railCond,
	input wire logic xcvrIlimCond,
	input wire logic ioIlimCond,
	input wire logic sensUvCond,
	input wire logic sensOvCond,
	input wire logic sensOtCond,
	input wire logic xcvrOtCond,
	input wire logic ioOtCond,
	// control bits from configuration
	input wire logic xcvrEnableSet,
	input wire logic xcvrEnableClr,
	input wire logic xcvrUnmaskWr,
	input wire logic xcvrUnmaskVal,
	input wire logic watchdogResetEnable,
	// crc content
	input wire logic [8*CFG_BYTES-1:0] cfgContent,
	input wire logic [7:0] cfgCrcExpected,
	input wire logic [8*NVM_BYTES-1:0] nvmContent,
	input wire logic [7:0] nvmCrcExpected,
	input wire logic nvmCheckStart,
	// device state and watchdog events
	input wire logic diagState,
	input wire logic stateEntry,
	input wire logic wdGood,
	input wire logic wdBad,
	// read port
	input wire logic [1:0] rdSel,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	// regulator and safety outputs
	output logic xcvrRailEnable,
	output logic sensRegDisable,
	output logic ioRegDisable,
	output logic enableDriveAllowed,
	output logic watchdogFailure,
	output logic safeRequest
);
	logic rstMeta_q, rstSync_q;
	logic [7:0] supply_q, rail_q, protect_q;
	logic xcvrEn_q, unmask_q;
	logic cfgErr_q, nvmErr_q;
	logic [2:0] wdCnt_q;
	logic wdFail_q, nvmDone_q;
	logic sensDis_q, ioDis_q, endrvOk_q, safe_q;
	logic [7:0] rd_q;
	logic [7:0] cfgCrc, nvmCrc;
	logic [7:0] crcStat;

	function automatic logic [7:0] crc8(input logic [7:0] init, input logic [7:0] data);
		logic [7:0] c;
		c = init ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC8_POLY) : (c << 1);
		end
		return c;
	endfunction

	always_comb begin
		cfgCrc = CRC8_INIT;
		for (int b = 0; b < CFG_BYTES; b++) begin
			cfgCrc = crc8(cfgCrc, cfgContent[8*b +: 8]);
		end
		nvmCrc = CRC8_INIT;
		for (int b = 0; b < NVM_BYTES; b++) begin
			nvmCrc = crc8(nvmCrc, nvmContent[8*b +: 8]);
		end
	end

	// reset synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// live monitor flags
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			supply_q <= RST_SUPPLY_A;
			rail_q <= RST_RAIL_B;
			protect_q <= RST_PROTECT;
		end else begin
			supply_q <= supplyCond;
			rail_q <= railCond;
			protect_q[7] <= xcvrIlimCond | ~xcvrEn_q;
			protect_q[6] <= ioIlimCond;
			protect_q[5] <= sensUvCond;
			protect_q[4] <= sensOvCond;
			protect_q[BIT_PROT_RSV] <= 1'b0;
			protect_q[2] <= sensOtCond;
			protect_q[1] <= xcvrOtCond;
			protect_q[0] <= ioOtCond;
		end
	end

	// regulator side effects of overtemperature
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			xcvrEn_q <= 1'b0;
			unmask_q <= 1'b1;
			sensDis_q <= 1'b0;
			ioDis_q <= 1'b0;
		end else begin
			if (xcvrUnmaskWr) begin
				unmask_q <= xcvrUnmaskVal;
			end
			if (xcvrOtCond && unmask_q) begin
				xcvrEn_q <= 1'b0;
			end else if (xcvrEnableClr) begin
				xcvrEn_q <= 1'b0;
			end else if (xcvrEnableSet) begin
				xcvrEn_q <= 1'b1;
			end
			sensDis_q <= sensOtCond;
			ioDis_q <= ioOtCond;
		end
	end

	// crc error flags
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			cfgErr_q <= 1'b0;
			nvmErr_q <= 1'b0;
			nvmDone_q <= 1'b0;
		end else if (selfTestReinit) begin
			cfgErr_q <= 1'b0;
			nvmErr_q <= 1'b0;
			nvmDone_q <= 1'b0;
		end else begin
			nvmDone_q <= nvmCheckStart;
			if (cfgCrc != cfgCrcExpected) begin
				cfgErr_q <= 1'b1;
			end else begin
				cfgErr_q <= 1'b0;
			end
			if (nvmDone_q && (nvmCrc == nvmCrcExpected)) begin
				cfgErr_q <= 1'b0;
			end
			nvmErr_q <= (nvmCrc != nvmCrcExpected);
		end
	end

	// watchdog fail counter
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			wdCnt_q <= WD_CNT_DEFAULT;
			wdFail_q <= 1'b0;
		end else if (selfTestReinit) begin
			wdCnt_q <= WD_CNT_DEFAULT;
			wdFail_q <= 1'b0;
		end else if (stateEntry) begin
			wdCnt_q <= WD_CNT_DEFAULT;
		end else if (wdBad) begin
			if (wdCnt_q == WD_CNT_MAX) begin
				if (watchdogResetEnable) begin
					wdFail_q <= 1'b1;
				end
			end else begin
				wdCnt_q <= wdCnt_q + 3'h1;
			end
		end else if (wdGood && wdCnt_q != 3'h0) begin
			wdCnt_q <= wdCnt_q - 3'h1;
		end
	end

	// enable drive permission and safe request
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			endrvOk_q <= 1'b0;
			safe_q <= 1'b0;
		end else begin
			endrvOk_q <= (wdCnt_q < WD_CNT_ENABLE_BELOW);
			safe_q <= nvmErr_q & diagState;
		end
	end

	assign crcStat = {2'b00, cfgErr_q, nvmErr_q, 1'b0, wdCnt_q};

	// read port, registers are read only
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			rd_q <= 8'h00;
		end else if (rdStrobe) begin
			case (rdSel)
				SEL_SUPPLY_A: rd_q <= supply_q;
				SEL_RAIL_B: rd_q <= rail_q;
				SEL_PROTECT: rd_q <= protect_q;
				SEL_CRC_WD: rd_q <= crcStat;
				default: rd_q <= 8'h00;
			endcase
		end
	end

	assign rdData = rd_q;
	assign xcvrRailEnable = xcvrEn_q;
	assign sensRegDisable = sensDis_q;
	assign ioRegDisable = ioDis_q;
	assign enableDriveAllowed = endrvOk_q;
	assign watchdogFailure = wdFail_q;
	assign safeRequest = safe_q;

	// live monitor flag tracking
	a_supply_live: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		supply_q == $past(supplyCond))
		else $error("supply flags not live");

	a_rail_live: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		rail_q == $past(railCond))
		else $error("rail flags not live");

	a_ilim_disabled: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		!xcvrEn_q |=> protect_q[7])
		else $error("current limit not 1 when off");

	a_ilim_follow: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		xcvrEn_q |=> protect_q[7] == $past(xcvrIlimCond))
		else $error("current limit flag not live");

	a_io_ilim: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		$past(rstSync_q) |-> protect_q[6] == $past(ioIlimCond))
		else $error("io current limit flag not live");

	a_sens_flags: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		$past(rstSync_q) |-> protect_q[5:4] == {$past(sensUvCond), $past(sensOvCond)})
		else $error("sensor supply flags not live");

	a_xcvr_ot_flag: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		$past(rstSync_q) |-> protect_q[1] == $past(xcvrOtCond))
		else $error("transceiver overtemp flag not live");

	// regulator side effects
	a_ot_shutdown: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		xcvrOtCond && unmask_q |=> !xcvrEn_q)
		else $error("overtemp did not disable");

	a_ot_masked: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		xcvrOtCond && !unmask_q && xcvrEn_q && !xcvrEnableClr |=> xcvrEn_q)
		else $error("masked overtemp changed enable");

	a_sens_hold: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		sensOtCond |=> sensDis_q && protect_q[2])
		else $error("sensor not held off");

	a_io_hold: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		ioOtCond |=> ioDis_q && protect_q[0])
		else $error("io not held off");

	// crc flags
	a_cfg_crc: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		cfgCrc != cfgCrcExpected && !(nvmDone_q && nvmCrc == nvmCrcExpected)
		&& !selfTestReinit |=> cfgErr_q)
		else $error("config crc mismatch not flagged");

	a_nvm_clear: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		nvmDone_q && nvmCrc == nvmCrcExpected && !selfTestReinit |=> !cfgErr_q)
		else $error("clean nvm check did not clear config error");

	a_nvm_crc: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		$past(rstSync_q) && !$past(selfTestReinit) |-> nvmErr_q == $past(nvmCrc != nvmCrcExpected))
		else $error("nvm crc flag not live");

	a_safe_req: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		nvmErr_q && diagState |=> safe_q)
		else $error("no safe request");

	// watchdog fail counter
	a_wd_entry: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		stateEntry && !selfTestReinit |=> wdCnt_q == 3'h5)
		else $error("no reload");

	a_wd_inc: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		wdBad && !stateEntry && !selfTestReinit && wdCnt_q < 3'h7 |=> wdCnt_q == $past(wdCnt_q) + 3'h1)
		else $error("no increment");

	a_wd_dec: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		wdGood && !wdBad && !stateEntry && !selfTestReinit && wdCnt_q != 3'h0
		|=> wdCnt_q == $past(wdCnt_q) - 3'h1)
		else $error("no decrement");

	a_wd_floor: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		wdGood && !wdBad && !stateEntry && !selfTestReinit && wdCnt_q == 3'h0 |=> wdCnt_q == 3'h0)
		else $error("counter wrapped below zero");

	a_wd_sat: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		wdBad && wdCnt_q == 3'h7 && !stateEntry && !selfTestReinit |=> wdCnt_q == 3'h7)
		else $error("counter wrapped above seven");

	a_watchdog_failure_status: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		wdBad && wdCnt_q == 3'h7 && watchdogResetEnable && !stateEntry && !selfTestReinit |=> wdFail_q)
		else $error("watchdog failure missed");

	a_enable_drive_output_gate: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		endrvOk_q |-> $past(wdCnt_q) < 3'h5)
		else $error("enable drive too early");

	a_enable_drive_output_allow: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		wdCnt_q < WD_CNT_ENABLE_BELOW |=> endrvOk_q)
		else $error("enable drive not allowed");

	a_reinit_clear: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		selfTestReinit |=> wdCnt_q == WD_CNT_DEFAULT && !wdFail_q && !cfgErr_q && !nvmErr_q)
		else $error("self test did not reinitialise");

	// read port
	a_rsv_zero: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		rdData[7:6] == 2'b00 || $past(rdSel) != SEL_CRC_WD || !$past(rdStrobe))
		else $error("reserved bits nonzero");

	a_crc_rsv: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		$past(rdStrobe) && $past(rdSel) == SEL_CRC_WD |-> !rdData[3])
		else $error("crc register reserved bit nonzero");

	a_prot_rsv: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		$past(rdStrobe) && $past(rdSel) == SEL_PROTECT |-> !rdData[BIT_PROT_RSV])
		else $error("protection register reserved bit nonzero");

	a_rd_hold: assert property (@(posedge clk_sys) disable iff (!rstSync_q)
		!rdStrobe |=> $stable(rdData))
		else $error("read data changed without strobe");

	c_watchdog_failure_status: cover property (@(posedge clk_sys) disable iff (!rstSync_q) $rose(wdFail_q));
	c_ot_shut: cover property (@(posedge clk_sys) disable iff (!rstSync_q) $fell(xcvrEn_q));
	c_safe: cover property (@(posedge clk_sys) disable iff (!rstSync_q) $rose(safe_q));
	c_enable_drive_output: cover property (@(posedge clk_sys) disable iff (!rstSync_q) $rose(endrvOk_q));
	c_cfg_clear: cover property (@(posedge clk_sys) disable iff (!rstSync_q)
		nvmDone_q && cfgErr_q ##1 !cfgErr_q);
endmodule
`default_nettype wire

// ---- bench/ssr_mcu_model.sv ----
/*
 * microcontroller side: issues status read commands on the read port.
 * assumes rdData answers one cycle after the strobe and then holds.
 */
`default_nettype none
module ssr_mcu_model (
	// clock
	input wire logic clk_sys,
	// read port
	input wire logic [7:0] rdData,
	output var logic [1:0] rdSel,
	output var logic rdStrobe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		rdSel = 2'h0;
		rdStrobe = 1'b0;
	end
	// one read command, select held until the taking edge
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		@(posedge clk_sys);
		#2;
		rdSel = s;
		rdStrobe = 1'b1;
		@(posedge clk_sys);
		#2;
		rdStrobe = 1'b0;
		rdSel = ~s;
		@(posedge clk_sys);
		#2;
		d = rdData;
	endtask
endmodule
`default_nettype wire

// ---- bench/safety_status_registers_bench.sv ----
/*
 * self-checking bench for the safety status register bank.
 * assumes ssr_pkg, ssr_status_regs and ssr_mcu_model are compiled first.
 */
`default_nettype none
module safety_status_registers_bench import ssr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0, rst_n = 1'b0, reinit = 1'b0;
	logic [7:0] sup = 8'h00, rail = 8'h00, rd, cfgExp, nvmExp, rdData;
	logic xIlim = 0, ioIlim = 0, sUv = 0, sOv = 0, sOt = 0, xOt = 0, ioOt = 0;
	logic enSet = 0, enClr = 0, umWr = 0, umVal = 0, wdEn = 0, nvmGo = 0;
	logic diag = 0, entry = 0, good = 0, bad = 0, strobe;
	logic [31:0] cfg = 32'h12345678;
	logic [63:0] nvm = 64'h0123456789ABCDEF;
	logic [1:0] sel;
	logic xEn, sDis, ioDis, edOk, wdFail, safeReq;
	int mismatches = 0, samplesChecked = 0;
	always #12.5 clk_sys = ~clk_sys;
	ssr_status_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .selfTestReinit(reinit),
		.supplyCond(sup), .railCond(rail), .xcvrIlimCond(xIlim), .ioIlimCond(ioIlim),
		.sensUvCond(sUv), .sensOvCond(sOv), .sensOtCond(sOt), .xcvrOtCond(xOt),
		.ioOtCond(ioOt), .xcvrEnableSet(enSet), .xcvrEnableClr(enClr), .xcvrUnmaskWr(umWr),
		.xcvrUnmaskVal(umVal), .watchdogResetEnable(wdEn), .cfgContent(cfg),
		.cfgCrcExpected(cfgExp), .nvmContent(nvm), .nvmCrcExpected(nvmExp),
		.nvmCheckStart(nvmGo), .diagState(diag), .stateEntry(entry), .wdGood(good),
		.wdBad(bad), .rdSel(sel), .rdStrobe(strobe), .rdData(rdData),
		.xcvrRailEnable(xEn), .sensRegDisable(sDis), .ioRegDisable(ioDis),
		.enableDriveAllowed(edOk), .watchdogFailure(wdFail), .safeRequest(safeReq));
	ssr_mcu_model mcu_u (.clk_sys(clk_sys), .rdData(rdData), .rdSel(sel), .rdStrobe(strobe));
	function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 0; i < n; i++) begin
			c ^= d[8*i+:8];
			for (int j = 0; j < 8; j++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
		end
		return c;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samplesChecked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdChk(input logic [1:0] s, input logic [7:0] e, input string nm);
		mcu_u.rd(s, rd);
		chk(nm, e, rd);
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", mismatches, samplesChecked);
		if (mismatches == 0 && samplesChecked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic tReset;
		rdChk(SEL_SUPPLY_A, RST_SUPPLY_A, "supA");
		rdChk(SEL_RAIL_B, RST_RAIL_B, "railB");
		rdChk(SEL_PROTECT, 8'h80, "prot");
		rdChk(SEL_CRC_WD, 8'h05, "crcWd");
	endtask
	task automatic tLive;
		for (int i = 0; i < 8; i++) begin
			sup = 8'h01 << i;
			rail = 8'h80 >> i;
			cyc(2);
			rdChk(SEL_SUPPLY_A, 8'h01 << i, "supA");
			rdChk(SEL_RAIL_B, 8'h80 >> i, "railB");
		end
		sup = 8'h00;
		rail = 8'h00;
		cyc(2);
		rdChk(SEL_SUPPLY_A, 8'h00, "supAClr");
		rdChk(SEL_RAIL_B, 8'h00, "railBClr");
	endtask
	task automatic tProt;
		enSet = 1;
		cyc(1);
		enSet = 0;
		for (int i = 0; i < 7; i++) begin
			logic [5:0] p;
			p = 6'h01 << i;
			{xIlim, ioIlim, sUv, sOv, sOt, ioOt} = p;
			cyc(2);
			rdChk(SEL_PROTECT, {p[5:2], 1'b0, p[1], 1'b0, p[0]}, "prot");
			chk("sensDis", {7'h00, p[1]}, {7'h00, sDis});
			chk("ioDis", {7'h00, p[0]}, {7'h00, ioDis});
		end
	endtask
	task automatic tOt;
		xOt = 1;
		cyc(3);
		chk("xEnOt", 8'h00, {7'h00, xEn});
		rdChk(SEL_PROTECT, 8'h82, "protOt");
		xOt = 0;
		umWr = 1;
		cyc(1);
		umWr = 0;
		enSet = 1;
		cyc(1);
		enSet = 0;
		xOt = 1;
		cyc(3);
		chk("xEnMask", 8'h01, {7'h00, xEn});
		rdChk(SEL_PROTECT, 8'h02, "protMask");
		xOt = 0;
		enClr = 1;
		cyc(1);
		enClr = 0;
		cyc(2);
		chk("xEnClr", 8'h00, {7'h00, xEn});
	endtask
	task automatic nvmCheck;
		nvmGo = 1;
		cyc(1);
		nvmGo = 0;
		cyc(2);
	endtask
	task automatic tCrc;
		cfgExp = ~cfgExp;
		cyc(2);
		rdChk(SEL_CRC_WD, 8'h25, "cfgErr");
		nvmGo = 1;
		cyc(1);
		nvmGo = 0;
		rdChk(SEL_CRC_WD, 8'h05, "cfgClr");
		cyc(1);
		rdChk(SEL_CRC_WD, 8'h25, "cfgSet");
		cfgExp = ~cfgExp;
		nvmExp = ~nvmExp;
		nvmCheck();
		rdChk(SEL_CRC_WD, 8'h15, "nvmErr");
		diag = 1;
		cyc(3);
		chk("safeReq", 8'h01, {7'h00, safeReq});
		diag = 0;
		nvmExp = ~nvmExp;
		nvmCheck();
		rdChk(SEL_CRC_WD, 8'h05, "nvmOk");
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
		cyc(2);
	endtask
	task automatic tWd;
		pulse(entry);
		chk("edOff", 8'h00, {7'h00, edOk});
		pulse(good);
		rdChk(SEL_CRC_WD, 8'h04, "cntDn");
		chk("edOn", 8'h01, {7'h00, edOk});
		for (int i = 0; i < 3; i++) pulse(bad);
		rdChk(SEL_CRC_WD, 8'h07, "cntUp");
		chk("noFail", 8'h00, {7'h00, wdFail});
		wdEn = 1;
		pulse(bad);
		chk("wdFail", 8'h01, {7'h00, wdFail});
		pulse(entry);
		rdChk(SEL_CRC_WD, 8'h05, "reload");
		pulse(reinit);
		chk("failClr", 8'h00, {7'h00, wdFail});
	endtask
	initial begin
		cfgExp = crc8({32'h00000000, cfg}, 4);
		nvmExp = crc8(nvm, 8);
		repeat (10) @(posedge clk_sys);
		#2;
		rst_n = 1;
		cyc(3);
		tReset();
		tLive();
		tProt();
		tOt();
		tCrc();
		tWd();
		report_and_stop();
	end
	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
